// ===== dmb_core_move.sv
// Move/branch execution sequencer: takes one decoded form, runs it for its
// clock count and raises pointer, stack and address side effects.
// Assumes: the decoder issues one form at a time and holds operands with it
`timescale 1ns/10ps
`default_nettype none
module dmb_core_move
  import dmb_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic                   issue_valid,
  output logic                        issue_ready,
  input  wire dmb_form_t              issue_form,
  input  wire logic                   issue_wide,
  input  wire logic                   issue_long_offset,
  input  wire logic                   issue_to_mem,
  input  wire logic [DMB_RLIST_W-1:0] reg_count,
  input  wire logic                   system_mode,
  input  wire logic                   flag_c,
  input  wire logic                   flag_z,
  input  wire logic                   flag_n,
  input  wire logic                   flag_v,
  input  wire logic [DMB_SEG_W-1:0]   segment_select,
  input  wire logic [DMB_WORD_W-1:0]  src_ptr,
  input  wire logic [DMB_WORD_W-1:0]  acc_value,
  input  wire logic [DMB_WORD_W-1:0]  data_pointer,
  input  wire logic [DMB_WORD_W-1:0]  pc_value,
  input  wire logic [7:0]             rel_offset,
  input  wire logic [3:0]             imm4,
  output logic                        busy,
  output logic                        done,
  output logic [DMB_LEN_W-1:0]        instr_bytes,
  output logic [DMB_CLK_W-1:0]        exec_clocks,
  output logic                        ptr_src_inc,
  output logic                        ptr_dst_inc,
  output logic                        use_user_stack,
  output logic                        code_fetch,
  output logic                        ext_data,
  output logic                        priv_fault,
  output logic                        branch_taken,
  output logic [DMB_WORD_W-1:0]       branch_target,
  output logic [DMB_SEG_W+DMB_WORD_W-1:0] code_addr,
  output logic [DMB_WORD_W-1:0]       sext_value
);
  dmb_state_t                       state_reg;
  logic [DMB_CLK_W-1:0]             count_reg;
  logic [DMB_LEN_W-1:0]             bytes_reg;
  logic [DMB_CLK_W-1:0]             clocks_reg;
  logic                             inc_src_reg;
  logic                             inc_dst_reg;
  logic                             user_stack_reg;
  logic                             code_fetch_reg;
  logic                             ext_data_reg;
  logic                             fault_reg;
  logic                             taken_reg;
  logic [DMB_WORD_W-1:0]            target_reg;
  logic [DMB_SEG_W+DMB_WORD_W-1:0]  code_addr_reg;
  logic [DMB_WORD_W-1:0]            sext_reg;
  logic                             accept;
  logic                             fault;
  logic                             go;
  logic                             cond_taken;
  logic [DMB_LEN_W-1:0]             tab_bytes;
  logic [DMB_CLK_W-1:0]             tab_clocks;
  logic                             is_stack_form;
  logic                             is_user_form;

  // Condition flags resolve taken or not before the clock count is chosen
  dmb_cond u_cond (
    .form   (issue_form),
    .flag_c (flag_c),
    .flag_z (flag_z),
    .flag_n (flag_n),
    .flag_v (flag_v),
    .taken  (cond_taken)
  );

  // Table lookup of length and execution time for the issued form
  dmb_timing u_timing (
    .form      (issue_form),
    .wide      (issue_wide),
    .long_off  (issue_long_offset),
    .reg_count (reg_count),
    .taken     (cond_taken),
    .bytes     (tab_bytes),
    .clocks    (tab_clocks)
  );

  // Issue handshake; a refused privileged form never enters execution
  assign issue_ready = (state_reg == ST_IDLE);
  assign accept      = issue_valid && issue_ready;
  assign fault       = (issue_form == F_USER_STACK_POINTER_MOVE) && !system_mode;
  assign go          = accept && !fault;
  assign done        = (state_reg == ST_EXEC) && (count_reg == '0);
  assign busy        = (state_reg == ST_EXEC);

  // Stack forms, and which of them are pinned to the user stack
  always_comb begin
    is_stack_form = 1'b0;
    is_user_form  = 1'b0;
    case (issue_form)
      F_PUSH_DIR, F_POP_DIR, F_PUSH_LIST, F_POP_LIST: is_stack_form = 1'b1;
      F_USER_STACK_PUSH_DIR, F_USER_STACK_POP_DIR,
      F_USER_STACK_PUSH_LIST, F_USER_STACK_POP_LIST: begin
        is_stack_form = 1'b1;
        is_user_form  = 1'b1;
      end
      default: is_stack_form = 1'b0;
    endcase
  end

  // Sequencer: count runs from clocks-1 down to zero, done on zero
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      count_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (go) begin
            state_reg <= ST_EXEC;
            count_reg <= tab_clocks - DMB_CLK_W'(1);
          end
        end
        ST_EXEC: begin
          if (count_reg == '0) begin
            state_reg <= ST_IDLE;
          end else begin
            count_reg <= count_reg - DMB_CLK_W'(1);
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Length and time of the form in flight, held for the whole execution
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bytes_reg  <= '0;
      clocks_reg <= '0;
      taken_reg  <= 1'b0;
    end else if (go) begin
      bytes_reg  <= tab_bytes;
      clocks_reg <= tab_clocks;
      taken_reg  <= cond_taken;
    end
  end

  // Pointer advance only after the access, so the old pointer addresses it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      inc_src_reg <= 1'b0;
      inc_dst_reg <= 1'b0;
    end else if (go) begin
      case (issue_form)
        F_AUTOINC: begin
          inc_src_reg <= !issue_to_mem;
          inc_dst_reg <= issue_to_mem;
        end
        F_IND_IND: begin
          inc_src_reg <= 1'b1;
          inc_dst_reg <= 1'b1;
        end
        F_CODE_MEMORY_READ: begin
          inc_src_reg <= 1'b1;
          inc_dst_reg <= 1'b0;
        end
        F_IMM_AUTOINC, F_SEXT_AUTOINC: begin
          inc_src_reg <= 1'b0;
          inc_dst_reg <= 1'b1;
        end
        default: begin
          inc_src_reg <= 1'b0;
          inc_dst_reg <= 1'b0;
        end
      endcase
    end
  end
  assign ptr_src_inc = done && inc_src_reg;
  assign ptr_dst_inc = done && inc_dst_reg;

  // Stack and memory-space selection for the form in flight
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      user_stack_reg <= 1'b0;
      code_fetch_reg <= 1'b0;
      ext_data_reg   <= 1'b0;
    end else if (go) begin
      user_stack_reg <= is_user_form || (is_stack_form && !system_mode);
      code_fetch_reg <= (issue_form == F_CODE_MEMORY_READ) ||
                        (issue_form == F_CODE_READ_DATA_POINTER_ACC) ||
                        (issue_form == F_CODE_READ_PC_ACC);
      ext_data_reg   <= (issue_form == F_EXTERNAL_DATA_MOVE);
    end
  end

  // Code-memory address; accumulator forms wrap within 64K
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      code_addr_reg <= '0;
    end else if (go) begin
      if (issue_form == F_CODE_MEMORY_READ) begin
        code_addr_reg <= {segment_select, src_ptr};
      end else if (issue_form == F_CODE_READ_DATA_POINTER_ACC) begin
        code_addr_reg <= {8'h00, acc_value + data_pointer};
      end else if (issue_form == F_CODE_READ_PC_ACC) begin
        code_addr_reg <= {8'h00, acc_value + pc_value};
      end
    end
  end

  // Sign-extended immediate, byte operations keep the upper byte clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sext_reg <= '0;
    end else if (go) begin
      if (issue_wide) begin
        sext_reg <= {{12{imm4[3]}}, imm4};
      end else begin
        sext_reg <= {8'h00, {4{imm4[3]}}, imm4};
      end
    end
  end

  // Branch target from the signed 8-bit relative offset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      target_reg <= '0;
    end else if (go) begin
      target_reg <= pc_value + {{8{rel_offset[7]}}, rel_offset};
    end
  end

  // Privilege fault is a one-cycle report of a refused issue
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= accept && fault;
    end
  end

  assign instr_bytes    = bytes_reg;
  assign exec_clocks    = clocks_reg;
  assign use_user_stack = user_stack_reg;
  assign code_fetch     = code_fetch_reg;
  assign ext_data       = ext_data_reg;
  assign priv_fault     = fault_reg;
  assign branch_taken   = taken_reg;
  assign branch_target  = target_reg;
  assign code_addr      = code_addr_reg;
  assign sext_value     = sext_reg;

  // Execution-time checks, counted from the accepting edge
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_run3;
    !done [*2] ##1 done;
  endsequence
  sequence s_run4;
    !done [*3] ##1 done;
  endsequence
  sequence s_run5;
    !done [*4] ##1 done;
  endsequence
  sequence s_run6;
    !done [*5] ##1 done;
  endsequence

  chk_reg_move_time: assert property (
    go && (issue_form == F_REG_REG) |=> s_run3 ##0 (instr_bytes == DMB_LEN_2))
    else $error("register move not done in 3 clocks");

  chk_offset_move: assert property (
    go && (issue_form == F_OFFSET) && issue_long_offset |=> s_run5 ##0 (instr_bytes == DMB_LEN_4))
    else $error("long offset move length or time wrong");

  chk_autoinc_step: assert property (
    go && (issue_form == F_AUTOINC) |=> !ptr_src_inc [*3] ##1 (done && ptr_src_inc != ptr_dst_inc))
    else $error("auto-increment pointer not advanced at the end");

  chk_ind_ind_both: assert property (
    go && (issue_form == F_IND_IND) |=> s_run6 ##0 (ptr_src_inc && ptr_dst_inc))
    else $error("indirect copy did not advance both pointers");

  chk_imm_direct_len: assert property (
    go && (issue_form == F_IMM_DIRECT) && issue_wide |=> s_run3 ##0 (instr_bytes == 3'h5))
    else $error("wide immediate to direct wrong");

  chk_usp_privilege: assert property (
    accept && (issue_form == F_USER_STACK_POINTER_MOVE) && !system_mode
      |=> priv_fault && !busy ##1 !priv_fault)
    else $error("user stack pointer move outside system mode not refused");

  chk_code_acc_addr: assert property (
    go && (issue_form == F_CODE_READ_DATA_POINTER_ACC) |=>
      (code_addr == {8'h00, $past(acc_value) + $past(data_pointer)}) && code_fetch)
    else $error("accumulator plus data pointer address wrong");

  chk_sext_extend: assert property (
    go && (issue_form == F_SEXT_REG) && issue_wide |=>
      (sext_value[15:4] == {12{sext_value[3]}}) && (sext_value[3:0] == $past(imm4)))
    else $error("sign extension wrong");

  chk_user_stack_pin: assert property (
    go && (issue_form == F_USER_STACK_PUSH_DIR) |=> use_user_stack throughout s_run5)
    else $error("user stack push left the user stack");

  chk_branch_not_taken: assert property (
    go && (issue_form == F_BRANCH_CARRY_CLEAR) && flag_c |=> s_run3 ##0 !branch_taken)
    else $error("untaken branch not 3 clocks");

  chk_signed_greater: assert property (
    go && (issue_form == F_BRANCH_SIGNED_GREATER) && (flag_n == flag_v) && !flag_z
      |=> branch_taken ##0 s_run6)
    else $error("signed greater branch not taken in 6 clocks");

  chk_push_list_time: assert property (
    go && (issue_form == F_PUSH_LIST) && (reg_count == 4'h2) |=> s_run6)
    else $error("two-register push not 6 clocks");

  chk_pop_list_time: assert property (
    go && (issue_form == F_POP_LIST) && (reg_count == 4'h3) |=> !done [*7] ##1 done)
    else $error("three-register pop not 8 clocks");

  chk_xor_offset: assert property (
    go && (issue_form == F_XOR_OFFSET) |=> s_run6)
    else $error("xor offset form not 6 clocks");
endmodule
`default_nettype wire

// ===== dmb_pkg.sv
// Package: instruction forms, lengths and clock counts for the move/branch decoder
// Assumes: users run on mclk with a synchronous active-low reset
// Function
// - Register, indirect-to-register and register-to-indirect moves: 2 bytes, 3 clocks.
// - Offset-indirect moves: 3 bytes (8-bit) or 4 bytes (16-bit), 5 clocks.
// - Auto-increment indirect moves: 2 bytes, 4 clocks, pointer advanced after access.
// - Indirect-to-indirect move increments both pointers: 2 bytes, 6 clocks.
// - Register/direct and direct/indirect moves: 3 bytes, 4 clocks.
// - Immediate to register: 3 clocks, 3 or 4 bytes by data size.
// - Immediate to indirect: 3, 4 auto-increment, 5 offset clocks; 3 to 6 bytes.
// - Immediate to direct: 3 clocks, 4 or 5 bytes by data size.
// - Direct-to-direct move: 4 bytes, 4 clocks.
// - Register to or from user stack pointer only in system mode; 2 bytes, 3 clocks.
// - Code read uses segment select and source pointer, then increments; 2 bytes, 4 clocks.
// - Accumulator code reads add data pointer or program counter; 2 bytes, 6 clocks.
// - Sign-extended 4-bit immediate to register or indirect: 2 bytes, 3 or 4 clocks.
// - Sign-extended to direct 3 bytes 3 clocks; offset forms 3/4 bytes, 5 clocks.
// - External data moves via pointer register: 2 bytes, 6 clocks.
// - Push or pop direct operand on current stack: 3 bytes, 5 clocks.
// - User-stack push or pop of direct operand always uses user stack; 3 bytes, 5 clocks.
// - Register-list push and pop, either stack, are 2 bytes.
// - Exchange: registers 5 clocks 2 bytes; indirect 6/2; direct 6/3.
// - Carry and zero short branches: 2 bytes, 6 clocks taken, 3 not.
// - Unsigned-greater and signed compare branches: 2 bytes, rel8, 6 or 3 clocks.
// - XOR immediate to direct 4 clocks 4/5 bytes; offset form 6 clocks 4-6 bytes.
// - Register-list push costs 3 clocks per register.
// - Register-list pop costs 4 clocks, plus 2 per further register.
package dmb_pkg;
  localparam int DMB_LEN_W   = 3;
  localparam int DMB_CLK_W   = 6;
  localparam int DMB_RLIST_W = 4;
  localparam int DMB_WORD_W  = 16;
  localparam int DMB_SEG_W   = 8;

  // Base instruction lengths in bytes
  localparam logic [DMB_LEN_W-1:0] DMB_LEN_2 = 3'h2;
  localparam logic [DMB_LEN_W-1:0] DMB_LEN_3 = 3'h3;
  localparam logic [DMB_LEN_W-1:0] DMB_LEN_4 = 3'h4;

  // Execution times in clocks
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_MOVE      = 6'h03;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_AUTOINC   = 6'h04;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_OFFSET    = 6'h05;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_IND_IND   = 6'h06;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_DIRECT    = 6'h04;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_IMM       = 6'h03;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_CODE_ACC  = 6'h06;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_EXT       = 6'h06;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_STACK_DIR = 6'h05;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_XCH_REG   = 6'h05;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_XCH_MEM   = 6'h06;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_BR_TAKEN  = 6'h06;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_BR_NOT    = 6'h03;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_XOR_DIR   = 6'h04;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_XOR_OFF   = 6'h06;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_PUSH_EACH = 6'h03;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_POP_FIRST = 6'h04;
  localparam logic [DMB_CLK_W-1:0] DMB_CLK_POP_NEXT  = 6'h02;

  typedef enum logic [5:0] {
    F_REG_REG, F_REG_IND, F_OFFSET, F_AUTOINC, F_IND_IND, F_DIRECT,
    F_IMM_REG, F_IMM_IND, F_IMM_AUTOINC, F_IMM_OFFSET, F_IMM_DIRECT,
    F_DIR_DIR, F_USER_STACK_POINTER_MOVE, F_CODE_MEMORY_READ,
    F_CODE_READ_DATA_POINTER_ACC, F_CODE_READ_PC_ACC,
    F_SEXT_REG, F_SEXT_IND, F_SEXT_AUTOINC, F_SEXT_DIRECT, F_SEXT_OFFSET,
    F_EXTERNAL_DATA_MOVE, F_PUSH_DIR, F_POP_DIR,
    F_USER_STACK_PUSH_DIR, F_USER_STACK_POP_DIR,
    F_PUSH_LIST, F_POP_LIST, F_USER_STACK_PUSH_LIST, F_USER_STACK_POP_LIST,
    F_EXCHANGE_REG, F_EXCHANGE_IND, F_EXCHANGE_DIR,
    F_BRANCH_CARRY_CLEAR, F_BRANCH_CARRY_SET, F_BRANCH_ZERO_SET,
    F_BRANCH_ZERO_CLEAR, F_BRANCH_UNSIGNED_GREATER,
    F_BRANCH_SIGNED_GREATER_EQUAL, F_BRANCH_SIGNED_GREATER,
    F_XOR_DIRECT, F_XOR_OFFSET
  } dmb_form_t;

  typedef enum logic {ST_IDLE, ST_EXEC} dmb_state_t;
endpackage

// ===== dmb_cond.sv
// Branch condition evaluator for the short conditional branches
// Assumes: flags are stable in the cycle the branch is issued
`timescale 1ns/10ps
`default_nettype none
module dmb_cond
  import dmb_pkg::*;
(
  input  wire dmb_form_t form,
  input  wire logic      flag_c,
  input  wire logic      flag_z,
  input  wire logic      flag_n,
  input  wire logic      flag_v,
  output logic           taken
);
  // Non-branch forms report not taken
  always_comb begin
    case (form)
      F_BRANCH_CARRY_CLEAR:          taken = !flag_c;
      F_BRANCH_CARRY_SET:            taken = flag_c;
      F_BRANCH_ZERO_SET:             taken = flag_z;
      F_BRANCH_ZERO_CLEAR:           taken = !flag_z;
      F_BRANCH_UNSIGNED_GREATER:     taken = !flag_c && !flag_z;
      F_BRANCH_SIGNED_GREATER_EQUAL: taken = (flag_n == flag_v);
      F_BRANCH_SIGNED_GREATER:       taken = (flag_n == flag_v) && !flag_z;
      default:                       taken = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ===== dmb_timing.sv
// Length and execution-time table for the data move and branch forms
// Assumes: purely combinational; the caller registers the results
`timescale 1ns/10ps
`default_nettype none
module dmb_timing
  import dmb_pkg::*;
(
  input  wire dmb_form_t              form,
  input  wire logic                   wide,
  input  wire logic                   long_off,
  input  wire logic [DMB_RLIST_W-1:0] reg_count,
  input  wire logic                   taken,
  output logic [DMB_LEN_W-1:0]        bytes,
  output logic [DMB_CLK_W-1:0]        clocks
);
  logic [DMB_CLK_W-1:0] n;
  logic [DMB_LEN_W-1:0] ew;
  logic [DMB_LEN_W-1:0] el;

  // An empty register list is costed as one register
  always_comb begin
    n      = (reg_count == '0) ? DMB_CLK_W'(1) : DMB_CLK_W'(reg_count);
    ew     = DMB_LEN_W'(wide);
    el     = DMB_LEN_W'(long_off);
    bytes  = DMB_LEN_2;
    clocks = DMB_CLK_MOVE;
    case (form)
      F_REG_REG, F_REG_IND, F_USER_STACK_POINTER_MOVE: clocks = DMB_CLK_MOVE;
      F_OFFSET: begin
        bytes  = DMB_LEN_3 + el;
        clocks = DMB_CLK_OFFSET;
      end
      F_AUTOINC, F_CODE_MEMORY_READ: clocks = DMB_CLK_AUTOINC;
      F_IND_IND: clocks = DMB_CLK_IND_IND;
      F_DIRECT: begin
        bytes  = DMB_LEN_3;
        clocks = DMB_CLK_DIRECT;
      end
      F_IMM_REG, F_IMM_IND: begin
        bytes  = DMB_LEN_3 + ew;
        clocks = DMB_CLK_IMM;
      end
      F_IMM_AUTOINC: begin
        bytes  = DMB_LEN_3 + ew;
        clocks = DMB_CLK_AUTOINC;
      end
      F_IMM_OFFSET: begin
        bytes  = DMB_LEN_4 + ew + el;
        clocks = DMB_CLK_OFFSET;
      end
      F_IMM_DIRECT: begin
        bytes  = DMB_LEN_4 + ew;
        clocks = DMB_CLK_IMM;
      end
      F_DIR_DIR: begin
        bytes  = DMB_LEN_4;
        clocks = DMB_CLK_DIRECT;
      end
      F_CODE_READ_DATA_POINTER_ACC, F_CODE_READ_PC_ACC: clocks = DMB_CLK_CODE_ACC;
      F_SEXT_REG, F_SEXT_IND: clocks = DMB_CLK_IMM;
      F_SEXT_AUTOINC: clocks = DMB_CLK_AUTOINC;
      F_SEXT_DIRECT: begin
        bytes  = DMB_LEN_3;
        clocks = DMB_CLK_IMM;
      end
      F_SEXT_OFFSET: begin
        bytes  = DMB_LEN_3 + el;
        clocks = DMB_CLK_OFFSET;
      end
      F_EXTERNAL_DATA_MOVE: clocks = DMB_CLK_EXT;
      F_PUSH_DIR, F_POP_DIR, F_USER_STACK_PUSH_DIR, F_USER_STACK_POP_DIR: begin
        bytes  = DMB_LEN_3;
        clocks = DMB_CLK_STACK_DIR;
      end
      F_PUSH_LIST, F_USER_STACK_PUSH_LIST: clocks = n * DMB_CLK_PUSH_EACH;
      F_POP_LIST, F_USER_STACK_POP_LIST: begin
        clocks = DMB_CLK_POP_FIRST + (n - DMB_CLK_W'(1)) * DMB_CLK_POP_NEXT;
      end
      F_EXCHANGE_REG: clocks = DMB_CLK_XCH_REG;
      F_EXCHANGE_IND: clocks = DMB_CLK_XCH_MEM;
      F_EXCHANGE_DIR: begin
        bytes  = DMB_LEN_3;
        clocks = DMB_CLK_XCH_MEM;
      end
      F_XOR_DIRECT: begin
        bytes  = DMB_LEN_4 + ew;
        clocks = DMB_CLK_XOR_DIR;
      end
      F_XOR_OFFSET: begin
        bytes  = DMB_LEN_4 + ew + el;
        clocks = DMB_CLK_XOR_OFF;
      end
      default: begin
        bytes  = DMB_LEN_2;
        clocks = taken ? DMB_CLK_BR_TAKEN : DMB_CLK_BR_NOT;
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== dmb_code_mem_model.sv
// Code memory seen by the sequencer's fetch address
// Assumes: one core clock; answers one cycle after a fetch request
`timescale 1ns/10ps
`default_nettype none
module dmb_code_mem_model (
  input  wire logic        mclk,
  input  wire logic        code_fetch,
  input  wire logic [23:0] code_addr,
  output logic [7:0]       rdata
);
  // No fetch: show the inverse of the last value, not a stale byte
  always_ff @(posedge mclk) begin
    if (code_fetch) begin
      rdata <= code_addr[7:0] ^ 8'hA5;
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule
`default_nettype wire

// ===== data_move_branch_timing_tb.sv
// Bench for the move/branch sequencer: lengths, clocks, side effects
// Assumes: dmb_pkg and the design files are compiled before this file
`timescale 1ns/10ps
`default_nettype none
module data_move_branch_timing_tb;
  import dmb_pkg::*;
  `define CHK(nm,e,g) begin n_tests++; if ((g)!==(e)) begin failures++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
  logic mclk, resetn, valid, ready, wide, lng, tom, sys, fc, fz, fn, fv, busy, done;
  logic psi, pdi, uus, cf, ext, pf, bt, si, di;
  dmb_form_t form;
  logic [3:0] cnt, imm;
  logic [7:0] seg, rel, rd;
  logic [15:0] src, acc, dp, pc, tgt, sx;
  logic [2:0] nb;
  logic [5:0] nc;
  logic [23:0] ca;
  int failures, n_tests;
  dmb_core_move u_dut (.mclk(mclk), .resetn(resetn), .issue_valid(valid), .issue_ready(ready),
    .issue_form(form), .issue_wide(wide), .issue_long_offset(lng), .issue_to_mem(tom),
    .reg_count(cnt), .system_mode(sys), .flag_c(fc), .flag_z(fz), .flag_n(fn), .flag_v(fv),
    .segment_select(seg), .src_ptr(src), .acc_value(acc), .data_pointer(dp), .pc_value(pc),
    .rel_offset(rel), .imm4(imm), .busy(busy), .done(done), .instr_bytes(nb), .exec_clocks(nc),
    .ptr_src_inc(psi), .ptr_dst_inc(pdi), .use_user_stack(uus), .code_fetch(cf),
    .ext_data(ext), .priv_fault(pf), .branch_taken(bt), .branch_target(tgt), .code_addr(ca),
    .sext_value(sx));
  dmb_code_mem_model u_mem (.mclk(mclk), .code_fetch(cf), .code_addr(ca), .rdata(rd));
  // One accepted form, timed from the accept edge to the done pulse
  task automatic run(dmb_form_t f, logic w, logic l, logic [3:0] c, int eb, int ec);
    int n;
    n = 1;
    form = f; wide = w; lng = l; cnt = c; valid = 1'b1;
    @(posedge mclk) #1 valid = 1'b0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge mclk) #1 n++;
    end
    si = psi; di = pdi;
    `CHK("bytes", eb, nb)
    `CHK("clocks", ec, nc)
    `CHK("done cycle", ec, n)
    `CHK("busy", 2'h1, {ready, busy})
    @(posedge mclk) #1;
    `CHK("ready", 2'h2, {ready, busy})
  endtask
  task automatic br(dmb_form_t f, logic c, logic z, logic n, logic v, logic t);
    fc = c; fz = z; fn = n; fv = v;
    run(f, 1'b0, 1'b0, 4'h0, 2, t ? 6 : 3);
    `CHK("taken", t, bt)
  endtask
  task automatic t_moves();
    run(F_REG_REG, 0, 0, 0, 2, 3); run(F_REG_IND, 0, 0, 0, 2, 3);
    run(F_OFFSET, 0, 0, 0, 3, 5); run(F_OFFSET, 0, 1, 0, 4, 5);
    run(F_AUTOINC, 1, 0, 0, 2, 4); `CHK("dst inc", 2'h1, {si, di})
    tom = 1'b0; run(F_AUTOINC, 0, 0, 0, 2, 4); tom = 1'b1;
    `CHK("src inc", 2'h2, {si, di})
    run(F_IND_IND, 0, 0, 0, 2, 6); `CHK("both inc", 2'h3, {si, di})
    run(F_DIRECT, 0, 0, 0, 3, 4); run(F_DIR_DIR, 0, 0, 0, 4, 4);
    run(F_IMM_REG, 0, 0, 0, 3, 3); run(F_IMM_REG, 1, 0, 0, 4, 3);
    run(F_IMM_IND, 1, 0, 0, 4, 3); run(F_IMM_AUTOINC, 0, 0, 0, 3, 4);
    run(F_IMM_OFFSET, 1, 1, 0, 6, 5); run(F_IMM_DIRECT, 1, 0, 0, 5, 3);
    run(F_EXCHANGE_REG, 0, 0, 0, 2, 5); run(F_EXCHANGE_IND, 0, 0, 0, 2, 6);
    run(F_EXCHANGE_DIR, 0, 0, 0, 3, 6); run(F_XOR_DIRECT, 1, 0, 0, 5, 4);
    run(F_XOR_OFFSET, 0, 1, 0, 5, 6); run(F_EXTERNAL_DATA_MOVE, 0, 0, 0, 2, 6);
    `CHK("ext", 1'b1, ext)
  endtask
  task automatic t_code_sext();
    run(F_CODE_MEMORY_READ, 0, 0, 0, 2, 4); `CHK("inc", 1'b1, si)
    `CHK("code addr", {8'h3C, 16'h1234}, ca)
    `CHK("fetch", 1'b1, cf)
    `CHK("code data", 8'h91, rd)
    run(F_CODE_READ_DATA_POINTER_ACC, 0, 0, 0, 2, 6); `CHK("dp addr", 24'h00F000, ca)
    // Accumulator plus program counter wraps within 64K here
    run(F_CODE_READ_PC_ACC, 0, 0, 0, 2, 6); `CHK("pc addr", 24'h000000, ca)
    run(F_SEXT_REG, 1, 0, 0, 2, 3); `CHK("sext", 16'hFFF9, sx)
    run(F_SEXT_AUTOINC, 1, 0, 0, 2, 4); run(F_SEXT_DIRECT, 0, 0, 0, 3, 3);
    run(F_SEXT_OFFSET, 0, 1, 0, 4, 5);
  endtask
  task automatic t_stack();
    run(F_PUSH_DIR, 0, 0, 0, 3, 5); run(F_POP_DIR, 1, 0, 0, 3, 5);
    `CHK("cur stk", 1'b1, uus)
    sys = 1'b1;
    run(F_PUSH_DIR, 0, 0, 0, 3, 5); `CHK("sys stk", 1'b0, uus)
    run(F_USER_STACK_PUSH_DIR, 1, 0, 0, 3, 5); `CHK("user push", 1'b1, uus)
    run(F_USER_STACK_POP_DIR, 0, 0, 0, 3, 5); `CHK("user stk", 1'b1, uus)
    run(F_PUSH_LIST, 0, 0, 4, 2, 12); run(F_USER_STACK_PUSH_LIST, 1, 0, 1, 2, 3);
    run(F_PUSH_LIST, 0, 0, 2, 2, 6);
    run(F_POP_LIST, 0, 0, 3, 2, 8); run(F_USER_STACK_POP_LIST, 0, 0, 1, 2, 4);
    run(F_USER_STACK_POINTER_MOVE, 0, 0, 0, 2, 3);
    sys = 1'b0; form = F_USER_STACK_POINTER_MOVE; valid = 1'b1;
    @(posedge mclk) #1 valid = 1'b0;
    `CHK("fault", 2'h2, {pf, busy})
    @(posedge mclk) #1;
  endtask
  task automatic t_branch();
    br(F_BRANCH_CARRY_CLEAR, 0, 1, 0, 0, 1); br(F_BRANCH_CARRY_SET, 0, 0, 0, 0, 0);
    br(F_BRANCH_CARRY_CLEAR, 1, 0, 0, 0, 0);
    br(F_BRANCH_ZERO_SET, 1, 1, 0, 0, 1); br(F_BRANCH_ZERO_CLEAR, 0, 1, 0, 0, 0);
    `CHK("target", 16'h0FF0, tgt)
    br(F_BRANCH_UNSIGNED_GREATER, 0, 0, 1, 0, 1); br(F_BRANCH_UNSIGNED_GREATER, 0, 1, 0, 0, 0);
    br(F_BRANCH_SIGNED_GREATER_EQUAL, 1, 0, 1, 1, 1); br(F_BRANCH_SIGNED_GREATER_EQUAL, 0, 0, 1, 0, 0);
    br(F_BRANCH_SIGNED_GREATER, 0, 0, 0, 0, 1); br(F_BRANCH_SIGNED_GREATER, 0, 1, 1, 1, 0);
  endtask
  task automatic give_verdict();
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Clock, 5 ns period
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Whole run is a few hundred cycles; 20000 cycles means a hang
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
  initial begin
    failures = 0; n_tests = 0; resetn = 1'b0; valid = 1'b0; form = F_REG_REG; wide = 1'b0;
    lng = 1'b0; tom = 1'b1; cnt = 4'h0; sys = 1'b0; fc = 1'b0; fz = 1'b0; fn = 1'b0; fv = 1'b0;
    seg = 8'h3C; src = 16'h1234; acc = 16'hF000; dp = 16'h0000; pc = 16'h1000; rel = 8'hF0; imm = 4'h9;
    repeat (12) @(posedge mclk);
    #1 resetn = 1'b1;
    t_moves(); t_code_sext(); t_stack();
    acc = 16'hFFFF; t_branch();
    give_verdict();
  end
endmodule
`default_nettype wire
